/* File: logic/pin_remap_pkg.sv */
package pin_remap_pkg;

    // ==========================================================================
    // geometry
    // ==========================================================================
    localparam int unsigned NUM_PINS      = 44;
    localparam int unsigned CODE_W        = 6;
    localparam int unsigned NUM_FIELDS    = 14;
    localparam int unsigned NUM_OUT_PINS  = 2;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned REG_W         = 16;
    localparam int unsigned STRB_W        = 4;

    // ==========================================================================
    // register byte addresses
    // ==========================================================================
    localparam logic [7:0] ADDR_IRQ_ONE      = 8'h00;
    localparam logic [7:0] ADDR_IRQ_TWO_THR  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_FOUR     = 8'h08;
    localparam logic [7:0] ADDR_TMR_TWO_THR  = 8'h0c;
    localparam logic [7:0] ADDR_TMR_FOUR_FIV = 8'h10;
    localparam logic [7:0] ADDR_CAP_ONE_TWO  = 8'h1c;
    localparam logic [7:0] ADDR_CAP_THR_FOUR = 8'h20;
    localparam logic [7:0] ADDR_CAP_FIV_SIX  = 8'h24;
    localparam logic [7:0] ADDR_OUT_SELECT   = 8'h40;
    localparam logic [7:0] ADDR_OSC_CONTROL  = 8'h80;

    // ==========================================================================
    // field placement, one entry per peripheral input (index = PERIPH_SIG_O bit)
    // order: irq1 irq2 irq3 irq4 tmr2 tmr3 tmr4 tmr5 cap1 cap2 cap3 cap4 cap5 cap6
    // ==========================================================================
    localparam logic [7:0] FIELD_ADDR [NUM_FIELDS] = '{
        ADDR_IRQ_ONE, ADDR_IRQ_TWO_THR, ADDR_IRQ_TWO_THR, ADDR_IRQ_FOUR,
        ADDR_TMR_TWO_THR, ADDR_TMR_TWO_THR, ADDR_TMR_FOUR_FIV, ADDR_TMR_FOUR_FIV,
        ADDR_CAP_ONE_TWO, ADDR_CAP_ONE_TWO, ADDR_CAP_THR_FOUR, ADDR_CAP_THR_FOUR,
        ADDR_CAP_FIV_SIX, ADDR_CAP_FIV_SIX};
    localparam int unsigned FIELD_LSB [NUM_FIELDS] = '{
        8, 0, 8, 0, 0, 8, 0, 8, 0, 8, 0, 8, 0, 8};
    localparam int unsigned OUT_FIELD_LSB [NUM_OUT_PINS] = '{0, 8};

    // ==========================================================================
    // codes and reset values
    // ==========================================================================
    localparam logic [5:0] SEL_RESET       = 6'h3f;
    localparam logic [5:0] LAST_PIN_CODE   = 6'h2b;
    localparam logic [5:0] FUNC_NULL       = 6'h00;
    localparam logic [5:0] FUNC_SERIAL_TX  = 6'h03;
    localparam logic [5:0] FUNC_SERIAL_RTS = 6'h04;
    localparam int unsigned LOCK_BIT       = 6;
    localparam logic       LOCK_RESET      = 1'b0;
    localparam logic [7:0] UNLOCK_KEY_ONE  = 8'h46;
    localparam logic [7:0] UNLOCK_KEY_TWO  = 8'h57;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b001,
        SEQ_FIRST = 3'b010,
        SEQ_ARMED = 3'b100
    } unlock_seq_e;

endpackage : pin_remap_pkg

/* File: logic/input_pin_remap_selectors.sv */
`timescale 1ns/1ns
module input_pin_remap_selectors (
    input  wire logic        CLK_I,
    input  wire logic        SRST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic [43:0] PIN_I,
    output logic      [13:0] PERIPH_SIG_O,
    input  wire logic        SERIAL_ONE_TRANSMIT_I,
    input  wire logic        SERIAL_ONE_REQUEST_TO_SEND_I,
    output logic      [1:0]  OUT_PIN_O,
    output logic      [1:0]  OUT_PIN_OE_O,
    output logic             REMAP_WRITE_LOCK_O
);

    // ==========================================================================
    // decoding helpers
    // ==========================================================================
    // code beyond the last implemented pin (incl. reset code) yields ground
    function automatic logic pick_pin(input logic [43:0] pins, input logic [5:0] code);
        logic result;
        result = 1'b0;
        if (code <= pin_remap_pkg::LAST_PIN_CODE)
        begin
            result = pins[code];
        end
        return result;
    endfunction : pick_pin

    function automatic logic field_hit(input logic [7:0] addr, input int f);
        return addr == pin_remap_pkg::FIELD_ADDR[f];
    endfunction : field_hit

    function automatic logic addr_mapped(input logic [7:0] addr);
        logic hit;
        hit = 1'b0;
        for (int f = 0; f < pin_remap_pkg::NUM_FIELDS; f++)
        begin
            if (field_hit(addr, f))
            begin
                hit = 1'b1;
            end
        end
        if (addr == pin_remap_pkg::ADDR_OUT_SELECT || addr == pin_remap_pkg::ADDR_OSC_CONTROL)
        begin
            hit = 1'b1;
        end
        return hit;
    endfunction : addr_mapped

    // ==========================================================================
    // state
    // ==========================================================================
    logic [5:0]                sel_q [pin_remap_pkg::NUM_FIELDS];
    logic [5:0]                out_sel_q [pin_remap_pkg::NUM_OUT_PINS];
    logic                      lock_q;
    pin_remap_pkg::unlock_seq_e seq_q;
    logic [43:0]               pin_meta_q;
    logic [43:0]               pin_sync_q;
    logic [13:0]               periph_q;
    logic [1:0]                out_pin_q;
    logic [1:0]                out_oe_q;
    logic                      pready_q;
    logic                      pslverr_q;
    logic [31:0]               prdata_q;
    logic [31:0]               rd_word;
    logic                      setup_phase;
    logic                      wr_commit;
    logic                      sel_wr_ok;
    logic                      access_start;
    logic                      osc_wr;
    logic                      lock_wr;

    // ==========================================================================
    // apb handshake
    // ==========================================================================
    // ready is raised one cycle after setup, so every access ends in its first
    // access cycle; registering it keeps the port straight from a flip-flop
    assign setup_phase = PSEL_I & ~PENABLE_I;
    assign wr_commit   = PSEL_I & PENABLE_I & pready_q & PWRITE_I;
    assign sel_wr_ok   = wr_commit & ~lock_q;

    assign access_start = setup_phase & ~pready_q;
    assign osc_wr       = wr_commit & (PADDR_I == pin_remap_pkg::ADDR_OSC_CONTROL) & PSTRB_I[0];
    assign lock_wr      = osc_wr & (seq_q == pin_remap_pkg::SEQ_ARMED);

    always_comb
    begin
        rd_word = 32'h0000_0000;
        for (int f = 0; f < pin_remap_pkg::NUM_FIELDS; f++)
        begin
            if (field_hit(PADDR_I, f))
            begin
                rd_word[pin_remap_pkg::FIELD_LSB[f] +: 6] = sel_q[f];
            end
        end
        if (PADDR_I == pin_remap_pkg::ADDR_OUT_SELECT)
        begin
            for (int p = 0; p < pin_remap_pkg::NUM_OUT_PINS; p++)
            begin
                rd_word[pin_remap_pkg::OUT_FIELD_LSB[p] +: 6] = out_sel_q[p];
            end
        end
        if (PADDR_I == pin_remap_pkg::ADDR_OSC_CONTROL)
        begin
            rd_word[pin_remap_pkg::LOCK_BIT] = lock_q;
        end
    end

    // ready is a one-cycle pulse in the first access cycle
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            pready_q <= 1'b0;
        end
        else
        begin
            pready_q <= access_start;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            pslverr_q <= 1'b0;
        end
        else if (access_start)
        begin
            pslverr_q <= ~addr_mapped(PADDR_I);
        end
        else
        begin
            pslverr_q <= 1'b0;
        end
    end

    // read data is captured at setup and held until the next setup, so a
    // master that samples late still finds it after ready has dropped
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (access_start)
        begin
            prdata_q <= PWRITE_I ? 32'h0000_0000 : rd_word;
        end
    end

    // ==========================================================================
    // input selector registers
    // ==========================================================================
    // one 6-bit field per peripheral input; the bits between fields have no
    // storage at all, so writes there vanish and reads come back zero
    for (genvar f = 0; f < pin_remap_pkg::NUM_FIELDS; f++)
    begin : g_sel
        always_ff @(posedge CLK_I)
        begin
            if (SRST_I)
            begin
                sel_q[f] <= pin_remap_pkg::SEL_RESET;
            end
            else if (sel_wr_ok && field_hit(PADDR_I, f)
                     && PSTRB_I[pin_remap_pkg::FIELD_LSB[f] / 8])
            begin
                sel_q[f] <= PWDATA_I[pin_remap_pkg::FIELD_LSB[f] +: 6];
            end
        end
    end

    // ==========================================================================
    // output selector register, remappable pins two and three
    // ==========================================================================
    for (genvar p = 0; p < pin_remap_pkg::NUM_OUT_PINS; p++)
    begin : g_out
        always_ff @(posedge CLK_I)
        begin
            if (SRST_I)
            begin
                out_sel_q[p] <= pin_remap_pkg::FUNC_NULL;
            end
            else if (sel_wr_ok && PADDR_I == pin_remap_pkg::ADDR_OUT_SELECT
                     && PSTRB_I[pin_remap_pkg::OUT_FIELD_LSB[p] / 8])
            begin
                out_sel_q[p] <= PWDATA_I[pin_remap_pkg::OUT_FIELD_LSB[p] +: 6];
            end
        end

        // unknown function codes leave the pin undriven rather than guess
        always_ff @(posedge CLK_I)
        begin
            if (SRST_I)
            begin
                out_pin_q[p] <= 1'b0;
                out_oe_q[p]  <= 1'b0;
            end
            else
            begin
                case (out_sel_q[p])
                    pin_remap_pkg::FUNC_SERIAL_TX:
                    begin
                        out_pin_q[p] <= SERIAL_ONE_TRANSMIT_I;
                        out_oe_q[p]  <= 1'b1;
                    end
                    pin_remap_pkg::FUNC_SERIAL_RTS:
                    begin
                        out_pin_q[p] <= SERIAL_ONE_REQUEST_TO_SEND_I;
                        out_oe_q[p]  <= 1'b1;
                    end
                    default:
                    begin
                        out_pin_q[p] <= 1'b0;
                        out_oe_q[p]  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================================
    // lock bit and unlock key sequence
    // ==========================================================================
    // any write between the keys and the lock write, other than a repeated first key, aborts the sequence,
    // which keeps a stray store from arming the lock change
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            seq_q  <= pin_remap_pkg::SEQ_IDLE;
        end
        else if (wr_commit)
        begin
            if (PADDR_I != pin_remap_pkg::ADDR_OSC_CONTROL || !PSTRB_I[0])
            begin
                seq_q <= pin_remap_pkg::SEQ_IDLE;
            end
            else
            begin
                case (seq_q)
                    pin_remap_pkg::SEQ_ARMED:
                    begin
                        seq_q  <= pin_remap_pkg::SEQ_IDLE;
                    end
                    pin_remap_pkg::SEQ_FIRST:
                    begin
                        if (PWDATA_I[7:0] == pin_remap_pkg::UNLOCK_KEY_TWO)
                        begin
                            seq_q <= pin_remap_pkg::SEQ_ARMED;
                        end
                        else if (PWDATA_I[7:0] == pin_remap_pkg::UNLOCK_KEY_ONE)
                        begin
                            seq_q <= pin_remap_pkg::SEQ_FIRST;
                        end
                        else
                        begin
                            seq_q <= pin_remap_pkg::SEQ_IDLE;
                        end
                    end
                    pin_remap_pkg::SEQ_IDLE:
                    begin
                        if (PWDATA_I[7:0] == pin_remap_pkg::UNLOCK_KEY_ONE)
                        begin
                            seq_q <= pin_remap_pkg::SEQ_FIRST;
                        end
                    end
                    default:
                    begin
                        seq_q <= pin_remap_pkg::SEQ_IDLE;
                    end
                endcase
            end
        end
    end

    // lock moves only on the write that follows both keys; any other value
    // written there just leaves it where it is
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            lock_q <= pin_remap_pkg::LOCK_RESET;
        end
        else if (lock_wr)
        begin
            lock_q <= PWDATA_I[pin_remap_pkg::LOCK_BIT];
        end
    end

    // ==========================================================================
    // pin synchronisers and peripheral input muxes
    // ==========================================================================
    // pins are asynchronous; the mux only ever sees the second stage
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            pin_meta_q <= 44'h000_0000_0000;
        end
        else
        begin
            pin_meta_q <= PIN_I;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            pin_sync_q <= 44'h000_0000_0000;
        end
        else
        begin
            pin_sync_q <= pin_meta_q;
        end
    end

    for (genvar f = 0; f < pin_remap_pkg::NUM_FIELDS; f++)
    begin : g_mux
        always_ff @(posedge CLK_I)
        begin
            if (SRST_I)
            begin
                periph_q[f] <= 1'b0;
            end
            else
            begin
                periph_q[f] <= pick_pin(pin_sync_q, sel_q[f]);
            end
        end
    end

    // ==========================================================================
    // outputs
    // ==========================================================================
    assign PRDATA_O           = prdata_q;
    assign PREADY_O           = pready_q;
    assign PSLVERR_O          = pslverr_q;
    assign PERIPH_SIG_O       = periph_q;
    assign OUT_PIN_O          = out_pin_q;
    assign OUT_PIN_OE_O       = out_oe_q;
    assign REMAP_WRITE_LOCK_O = lock_q;

endmodule : input_pin_remap_selectors

/* File: bench/pin_remap_asserts.sv */
`timescale 1ns/1ns
// ==========
// port checker
// ==========
module pin_remap_asserts (
    input wire logic        CLK_I,
    input wire logic        SRST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic [13:0] PERIPH_SIG_O,
    input wire logic [1:0]  OUT_PIN_O,
    input wire logic [1:0]  OUT_PIN_OE_O,
    input wire logic        REMAP_WRITE_LOCK_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    setup_gets_ready_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held too long");
    selector_no_error_a: assert property (PREADY_O && PADDR_I inside {8'h00, 8'h04, 8'h08, 8'h0c,
        8'h10, 8'h1c, 8'h20, 8'h24} |-> !PSLVERR_O)
        else $error("selector access flagged as error");
    error_reads_zero_a: assert property (PSLVERR_O && !PWRITE_I |-> PREADY_O && PRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    unused_bits_zero_a: assert property (PREADY_O && !PWRITE_I && PADDR_I != 8'h80
        |-> PRDATA_O[31:14] == 18'h0 && PRDATA_O[7:6] == 2'h0)
        else $error("unimplemented bits read nonzero");
    lock_needs_write_a: assert property ($changed(REMAP_WRITE_LOCK_O)
        |-> $past(SRST_I) || $past(PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h80))
        else $error("lock changed without control write");
    idle_pin_low_a: assert property ((OUT_PIN_O & ~OUT_PIN_OE_O) == 2'b00)
        else $error("undriven output pin not low");
    reset_state_a: assert property (@(posedge CLK_I) disable iff (1'b0) SRST_I
        |=> PERIPH_SIG_O == 14'h0 && OUT_PIN_OE_O == 2'b00 && !REMAP_WRITE_LOCK_O && !PREADY_O)
        else $error("reset state wrong");
endmodule : pin_remap_asserts

/* File: bench/pin_world.sv */
`timescale 1ns/1ns
// ==========
// pads and serial port one
// ==========
module pin_world (
    input  wire logic        clk_i,
    input  wire logic [43:0] pad_level_i,
    input  wire logic [1:0]  serial_level_i,
    output logic      [43:0] pin_o,
    output logic             tx_o,
    output logic             rts_o
);
    // levels move only after an edge, so the synchroniser sees clean steps
    always_ff @(posedge clk_i)
    begin
        pin_o <= pad_level_i;
        tx_o  <= serial_level_i[0];
        rts_o <= serial_level_i[1];
    end
endmodule : pin_world

/* File: bench/input_pin_remap_selectors_tb_top.sv */
`timescale 1ns/1ns
module input_pin_remap_selectors_tb_top;
    logic        clk = 1'b0, srst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rng = 32'hed83a780;
    logic [3:0]  pstrb = 4'h0;
    logic        pready, pslverr, tx, rts, lock;
    logic [43:0] pin, pad_level = 44'h0;
    logic [1:0]  serial_level = 2'b00, out_pin, out_oe;
    logic [13:0] periph;
    logic [32:0] exp_q[$];
    logic [5:0]  code [14];
    logic [31:0] img [10];
    int          fail_count = 0, comparisons = 0;

    always #10 clk = ~clk;

    input_pin_remap_selectors u_dut (.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .PIN_I(pin), .PERIPH_SIG_O(periph),
        .SERIAL_ONE_TRANSMIT_I(tx), .SERIAL_ONE_REQUEST_TO_SEND_I(rts), .OUT_PIN_O(out_pin),
        .OUT_PIN_OE_O(out_oe), .REMAP_WRITE_LOCK_O(lock));
    pin_world u_world (.clk_i(clk), .pad_level_i(pad_level), .serial_level_i(serial_level),
        .pin_o(pin), .tx_o(tx), .rts_o(rts));

    // ==========
    // helpers
    // ==========
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // one idle edge first, so a release never meets the next setup in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= w ? 4'hf : 4'h0;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task automatic build_img();
        for (int w = 0; w < 10; w++)
            img[w] = 32'h0;
        for (int i = 0; i < 14; i++)
            img[pin_remap_pkg::FIELD_ADDR[i][7:2]] |= 32'(code[i]) << pin_remap_pkg::FIELD_LSB[i];
    endtask : build_img

    task automatic write_img();
        build_img();
        for (int w = 0; w < 10; w++)
            if (w != 5 && w != 6)
                wr(8'(4 * w), img[w] | 32'hffffc0c0);
    endtask : write_img

    task automatic verify_regs();
        for (int w = 0; w < 10; w++)
            apb(1'b0, 8'(4 * w), 32'h0, (w == 5 || w == 6) ? {1'b1, 32'h0} : {1'b0, img[w]});
    endtask : verify_regs

    task automatic pins_check(input logic [43:0] p);
        logic [13:0] e;
        for (int i = 0; i < 14; i++)
            e[i] = (code[i] < 6'd44) ? p[code[i]] : 1'b0;
        @(posedge clk);
        pad_level <= p;
        repeat (5) @(posedge clk);
        #1;
        check("periph", {19'h0, e}, {19'h0, periph});
    endtask : pins_check

    // response watcher pops the oldest note on each completed transfer
    always @(posedge clk)
        if (psel && penable && pready === 1'b1)
            check("response", exp_q.size() > 0 ? exp_q.pop_front() : 33'h1_ffff_ffff, {pslverr, prdata});

    initial
    begin
        #400000;
        fail_count++;
        stop_test();
    end

    // ==========
    // tests
    // ==========
    initial
    begin
        logic [43:0] p;
        for (int i = 0; i < 14; i++)
            code[i] = 6'h3f;
        build_img();
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        #1;
        check("reset outputs", 33'h0, {16'h0, lock, out_oe, periph});
        verify_regs();
        pins_check(44'hfff_ffff_ffff);
        apb(1'b0, 8'h80, 32'h0, 33'h0);
        $display("reset test done");
        for (int r = 0; r < 3; r++)
        begin
            for (int i = 0; i < 14; i++)
            begin
                rng = xorshift(rng);
                code[i] = rng[5:0];
            end
            code[r] = 6'd43 + 6'(r);
            write_img();
            verify_regs();
            repeat (2)
            begin
                rng = xorshift(rng);
                p[31:0] = rng;
                rng = xorshift(rng);
                p[43:32] = rng[11:0];
                pins_check(p);
            end
        end
        apb(1'b1, 8'h14, 32'hffff, {1'b1, 32'h0});
        $display("routing test done");
        wr(8'h40, 32'h0403);
        apb(1'b0, 8'h40, 32'h0, {1'b0, 32'h0403});
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk);
            serial_level <= 2'(s);
            repeat (3) @(posedge clk);
            #1;
            check("out pins", {29'h0, 2'b11, 2'(s)}, {29'h0, out_oe, out_pin});
        end
        wr(8'h40, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        check("out idle", 33'h0, {29'h0, out_oe, out_pin});
        $display("output test done");
        wr(8'h80, 32'h46);
        wr(8'h80, 32'h57);
        wr(8'h80, 32'h40);
        apb(1'b0, 8'h80, 32'h0, {1'b0, 32'h40});
        wr(8'h00, 32'h1500);
        verify_regs();
        wr(8'h80, 32'h0);
        #1;
        check("lock", 33'h1, {32'h0, lock});
        wr(8'h80, 32'h46);
        wr(8'h80, 32'h57);
        wr(8'h80, 32'h0);
        wr(8'h00, 32'h1500);
        code[0] = 6'h15;
        build_img();
        verify_regs();
        $display("lock test done");
        stop_test();
    end
endmodule : input_pin_remap_selectors_tb_top

bind input_pin_remap_selectors pin_remap_asserts u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .PERIPH_SIG_O(PERIPH_SIG_O), .OUT_PIN_O(OUT_PIN_O), .OUT_PIN_OE_O(OUT_PIN_OE_O),
    .REMAP_WRITE_LOCK_O(REMAP_WRITE_LOCK_O));
